// ---- rtl/pmu_event_pkg.sv ----
package pmu_event_pkg;
  // register bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register map
  localparam logic [7:0] PRIMARY_EVENT_FLAGS_ADDR = 8'h39;
  localparam logic [7:0] PRIMARY_EVENT_MASKS_ADDR = 8'h3a;
  localparam logic [7:0] PIN_EDGE_FLAGS_UPPER_ADDR = 8'h3b;
  localparam logic [7:0] PIN_EDGE_MASKS_UPPER_ADDR = 8'h3c;
  localparam logic [7:0] REGULATOR_FAIL_FLAGS_LOW_ADDR = 8'h3d;
  localparam logic [7:0] REGULATOR_FAIL_MASKS_LOW_ADDR = 8'h3e;

  // reset values (pin-edge masks come from one-time-programmed straps)
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASKS_RESET = 8'hff;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // primary event bit positions
  localparam int PIN1_FALL_BIT = 7;
  localparam int PIN1_RISE_BIT = 6;
  localparam int OVERTEMP_BIT = 5;
  localparam int HOLD_RISE_BIT = 4;
  localparam int LONG_PRESS_BIT = 3;
  localparam int BUTTON_BIT = 2;
  localparam int SUPPLY_MON_BIT = 1;
  localparam int HOLD_FALL_BIT = 0;

  // pin-edge layout: pin p (2..5) rises at bit 2*(p-2), falls one above
  localparam int FIRST_UPPER_PIN = 2;
  localparam int UPPER_PIN_COUNT = 4;
  localparam int PIN5_FALL_BIT = 7;
  localparam int PIN5_RISE_BIT = 6;

  // regulator failure layout: linear 4..1 at bits 7..4, buck 4..1 at 3..0
  localparam int LINREG_BASE_BIT = 4;
  localparam int BUCK_BASE_BIT = 0;
  localparam int LINREG4_FAIL_BIT = 7;
  localparam int REG_COUNT = 4;
endpackage : pmu_event_pkg

// ---- rtl/pmu_event_flag_mask_bank.sv ----
// Function
// - pin-1 edge interrupts follow their mask bits
// - overtemp mask blocks overtemp interrupt
// - hold rise mask blocks hold rise
// - hold fall mask blocks hold fall
// - long-press mask blocks long-press interrupt
// - button mask blocks button event interrupt
// - supply monitor mask blocks its interrupt
// - pin-5 falling edge sets bit 7
// - pin-5 rising edge sets bit 6
// - pin-4 edges set bits 5 and 4
// - pin-3 edges set bits 3 and 2
// - pin-2 edges set bits 1 and 0
// - writing one clears flag, zero keeps it
// - pin flag stays zero without edge
// - flag registers reset to zero
// - pin mask bit per flag, one masks
// - linreg4 power-good fall sets bit 7
// - disabled regulator never sets failure flag
// - linreg3 and linreg2 falls set bits 6,5
// - failure flag stays zero without qualifying fall
// - power-good levels come from regulator comparators
// - bits 4..0: linreg1, buck4..buck1
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
module pmu_event_flag_mask_bank
  import pmu_event_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [pmu_event_pkg::ADDR_W-1:0] addr,
  input wire logic [pmu_event_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pmu_event_pkg::DATA_W-1:0] rdata,
  input wire logic [5:1] gp_pin_in,
  input wire logic power_hold_input,
  input wire logic button_press_evt,
  input wire logic button_long_press_evt,
  input wire logic overtemp_warn_evt,
  input wire logic supply_voltage_monitor,
  input wire logic [4:1] linreg_in_regulation,
  input wire logic [4:1] buck_in_regulation,
  input wire logic [4:1] linreg_enable,
  input wire logic [4:1] buck_enable,
  input wire logic [7:0] otp_pin_mask_default,
  output logic irq_req
);
  import pmu_event_pkg::*;

  logic [7:0] primary_event_flags_reg;
  logic [7:0] primary_event_masks_reg;
  logic [7:0] pin_edge_flags_upper_reg;
  logic [7:0] pin_edge_masks_upper_reg;
  logic [7:0] regulator_fail_flags_low_reg;
  logic [7:0] regulator_fail_masks_low_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;

  // previous input samples for edge detection
  logic [5:1] pin_prev_reg;
  logic hold_prev_reg;
  logic monitor_prev_reg;
  logic [7:0] good_prev_reg;
  logic [7:0] enable_prev_reg;
  logic armed_reg;

  logic [7:0] primary_set;
  logic [7:0] pin_set;
  logic [7:0] fail_set;
  logic [7:0] good_now;
  logic [7:0] enable_now;
  logic wr_primary_flags;
  logic wr_pin_flags;
  logic wr_fail_flags;
  logic pending;

  // decoded write-one-to-clear strobes
  assign wr_primary_flags = wr && (addr == PRIMARY_EVENT_FLAGS_ADDR);
  assign wr_pin_flags = wr && (addr == PIN_EDGE_FLAGS_UPPER_ADDR);
  assign wr_fail_flags = wr && (addr == REGULATOR_FAIL_FLAGS_LOW_ADDR);

  // comparator outputs packed in flag order: linreg 4..1 then buck 4..1
  assign good_now = {linreg_in_regulation, buck_in_regulation};
  assign enable_now = {linreg_enable, buck_enable};

  // edge history; armed stays low one cycle after reset so that the
  // reset value of the history cannot fake an edge
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_prev_reg <= 5'h00;
      hold_prev_reg <= 1'b0;
      monitor_prev_reg <= 1'b0;
      good_prev_reg <= 8'h00;
      enable_prev_reg <= 8'h00;
      armed_reg <= 1'b0;
    end else begin
      pin_prev_reg <= gp_pin_in;
      hold_prev_reg <= power_hold_input;
      monitor_prev_reg <= supply_voltage_monitor;
      good_prev_reg <= good_now;
      enable_prev_reg <= enable_now;
      armed_reg <= 1'b1;
    end
  end

  // primary events: pin 1 edges, hold edges, monitor fall, pulses
  always_comb begin
    primary_set = 8'h00;
    primary_set[PIN1_FALL_BIT] = armed_reg && pin_prev_reg[1] && !gp_pin_in[1];
    primary_set[PIN1_RISE_BIT] = armed_reg && !pin_prev_reg[1] && gp_pin_in[1];
    primary_set[OVERTEMP_BIT] = overtemp_warn_evt;
    primary_set[HOLD_RISE_BIT] = armed_reg && !hold_prev_reg && power_hold_input;
    primary_set[LONG_PRESS_BIT] = button_long_press_evt;
    primary_set[BUTTON_BIT] = button_press_evt;
    primary_set[SUPPLY_MON_BIT] = armed_reg && monitor_prev_reg && !supply_voltage_monitor;
    primary_set[HOLD_FALL_BIT] = armed_reg && hold_prev_reg && !power_hold_input;
  end

  // one edge detector pair per upper pin
  genvar g;
  generate
    for (g = 0; g < UPPER_PIN_COUNT; g++) begin : g_pin_edge
      assign pin_set[2*g] = armed_reg && !pin_prev_reg[g+FIRST_UPPER_PIN]
                            && gp_pin_in[g+FIRST_UPPER_PIN];
      assign pin_set[2*g+1] = armed_reg && pin_prev_reg[g+FIRST_UPPER_PIN]
                              && !gp_pin_in[g+FIRST_UPPER_PIN];
    end
  endgenerate

  // a fall counts only if the regulator was enabled before and after it,
  // so switching a regulator off never looks like a failure
  assign fail_set = armed_reg ? (good_prev_reg & ~good_now & enable_now & enable_prev_reg)
                              : 8'h00;

  // sticky flags: set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      primary_event_flags_reg <= FLAGS_RESET;
    end else begin
      primary_event_flags_reg <= (primary_event_flags_reg
                                  & ~(wr_primary_flags ? wdata : 8'h00)) | primary_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_edge_flags_upper_reg <= FLAGS_RESET;
    end else begin
      pin_edge_flags_upper_reg <= (pin_edge_flags_upper_reg
                                   & ~(wr_pin_flags ? wdata : 8'h00)) | pin_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regulator_fail_flags_low_reg <= FLAGS_RESET;
    end else begin
      regulator_fail_flags_low_reg <= (regulator_fail_flags_low_reg
                                       & ~(wr_fail_flags ? wdata : 8'h00)) | fail_set;
    end
  end

  // masks: plain read/write; pin masks take their default from straps
  always_ff @(posedge clk) begin
    if (rst) begin
      primary_event_masks_reg <= MASKS_RESET;
    end else if (wr && addr == PRIMARY_EVENT_MASKS_ADDR) begin
      primary_event_masks_reg <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_edge_masks_upper_reg <= otp_pin_mask_default;
    end else if (wr && addr == PIN_EDGE_MASKS_UPPER_ADDR) begin
      pin_edge_masks_upper_reg <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regulator_fail_masks_low_reg <= MASKS_RESET;
    end else if (wr && addr == REGULATOR_FAIL_MASKS_LOW_ADDR) begin
      regulator_fail_masks_low_reg <= wdata;
    end
  end

  // a mask bit of one removes that flag from the request
  assign pending = |(primary_event_flags_reg & ~primary_event_masks_reg)
                   || |(pin_edge_flags_upper_reg & ~pin_edge_masks_upper_reg)
                   || |(regulator_fail_flags_low_reg & ~regulator_fail_masks_low_reg);

  // request is registered, one cycle behind the flags: glitch-free pin
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= pending;
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata_reg <= RDATA_IDLE;
    end else begin
      case (addr)
        PRIMARY_EVENT_FLAGS_ADDR: rdata_reg <= primary_event_flags_reg;
        PRIMARY_EVENT_MASKS_ADDR: rdata_reg <= primary_event_masks_reg;
        PIN_EDGE_FLAGS_UPPER_ADDR: rdata_reg <= pin_edge_flags_upper_reg;
        PIN_EDGE_MASKS_UPPER_ADDR: rdata_reg <= pin_edge_masks_upper_reg;
        REGULATOR_FAIL_FLAGS_LOW_ADDR: rdata_reg <= regulator_fail_flags_low_reg;
        REGULATOR_FAIL_MASKS_LOW_ADDR: rdata_reg <= regulator_fail_masks_low_reg;
        default: rdata_reg <= RDATA_IDLE;
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign irq_req = irq_reg;

  // checks
  property p_pin5_fall;
    @(posedge clk) disable iff (rst)
    (armed_reg && pin_prev_reg[5] && !gp_pin_in[5]) |=> pin_edge_flags_upper_reg[PIN5_FALL_BIT];
  endproperty
  a_pin5_fall: assert property (p_pin5_fall) else $error("pin5 fall flag not set");

  property p_pin5_rise;
    @(posedge clk) disable iff (rst)
    (armed_reg && !pin_prev_reg[5] && gp_pin_in[5]) |=> pin_edge_flags_upper_reg[PIN5_RISE_BIT];
  endproperty
  a_pin5_rise: assert property (p_pin5_rise) else $error("pin5 rise flag not set");

  property p_w1c;
    @(posedge clk) disable iff (rst)
    (wr_pin_flags && pin_set == 8'h00)
      |=> pin_edge_flags_upper_reg == ($past(pin_edge_flags_upper_reg) & ~$past(wdata));
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one-to-clear misbehaved");

  property p_no_edge_stays_clear;
    @(posedge clk) disable iff (rst)
    (pin_edge_flags_upper_reg == 8'h00 && pin_set == 8'h00) |=> pin_edge_flags_upper_reg == 8'h00;
  endproperty
  a_no_edge_stays_clear: assert property (p_no_edge_stays_clear) else $error("pin flag rose");

  property p_reset_flags;
    @(posedge clk) rst |=> (pin_edge_flags_upper_reg == 8'h00
                            && regulator_fail_flags_low_reg == 8'h00 && !irq_reg);
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags not cleared by reset");

  property p_disabled_no_fail;
    @(posedge clk) disable iff (rst)
    (!linreg_enable[4] && !regulator_fail_flags_low_reg[LINREG4_FAIL_BIT])
      |=> !regulator_fail_flags_low_reg[LINREG4_FAIL_BIT];
  endproperty
  a_disabled_no_fail: assert property (p_disabled_no_fail) else $error("disabled reg flagged");

  property p_linreg4_fall;
    @(posedge clk) disable iff (rst)
    (armed_reg && good_prev_reg[7] && !linreg_in_regulation[4] && linreg_enable[4]
     && enable_prev_reg[7]) |=> regulator_fail_flags_low_reg[LINREG4_FAIL_BIT];
  endproperty
  a_linreg4_fall: assert property (p_linreg4_fall) else $error("linreg4 fail not flagged");

  property p_irq_follows;
    @(posedge clk) disable iff (rst)
    ##1 irq_reg == $past(pending);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("request wrong");

  property p_all_masked_quiet;
    @(posedge clk) disable iff (rst)
    (primary_event_masks_reg == 8'hff && pin_edge_masks_upper_reg == 8'hff
     && regulator_fail_masks_low_reg == 8'hff) |=> !irq_reg;
  endproperty
  a_all_masked_quiet: assert property (p_all_masked_quiet) else $error("masked request");

  property p_hold_rise_unmasked;
    @(posedge clk) disable iff (rst)
    (primary_event_flags_reg[HOLD_RISE_BIT] && !primary_event_masks_reg[HOLD_RISE_BIT])
      |=> irq_reg;
  endproperty
  a_hold_rise_unmasked: assert property (p_hold_rise_unmasked) else $error("no request");

  property p_read_data;
    @(posedge clk) disable iff (rst)
    (rd && addr == REGULATOR_FAIL_FLAGS_LOW_ADDR)
      |=> rdata == $past(regulator_fail_flags_low_reg) ##1 (rdata == 8'h00 || $past(rd));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  // per-event capture: sampled events (one edge per pin, the pulses, monitor and hold falls, linreg3) must land in their own flag bits
  property p_pin1_rise;
    @(posedge clk) disable iff (rst)
    (armed_reg && !pin_prev_reg[1] && gp_pin_in[1]) |=> primary_event_flags_reg[PIN1_RISE_BIT];
  endproperty
  a_pin1_rise: assert property (p_pin1_rise) else $error("pin1 rise flag not set");

  property p_pin4_rise;
    @(posedge clk) disable iff (rst)
    (armed_reg && !pin_prev_reg[4] && gp_pin_in[4]) |=> pin_edge_flags_upper_reg[4];
  endproperty
  a_pin4_rise: assert property (p_pin4_rise) else $error("pin4 rise flag not set");

  property p_pin3_fall;
    @(posedge clk) disable iff (rst)
    (armed_reg && pin_prev_reg[3] && !gp_pin_in[3]) |=> pin_edge_flags_upper_reg[3];
  endproperty
  a_pin3_fall: assert property (p_pin3_fall) else $error("pin3 fall flag not set");

  property p_pin2_rise;
    @(posedge clk) disable iff (rst)
    (armed_reg && !pin_prev_reg[2] && gp_pin_in[2]) |=> pin_edge_flags_upper_reg[0];
  endproperty
  a_pin2_rise: assert property (p_pin2_rise) else $error("pin2 rise flag not set");

  property p_overtemp_set;
    @(posedge clk) disable iff (rst)
    overtemp_warn_evt |=> primary_event_flags_reg[OVERTEMP_BIT];
  endproperty
  a_overtemp_set: assert property (p_overtemp_set) else $error("overtemp flag not set");

  property p_long_press_set;
    @(posedge clk) disable iff (rst)
    button_long_press_evt |=> primary_event_flags_reg[LONG_PRESS_BIT];
  endproperty
  a_long_press_set: assert property (p_long_press_set) else $error("long press not set");

  property p_button_set;
    @(posedge clk) disable iff (rst)
    button_press_evt |=> primary_event_flags_reg[BUTTON_BIT];
  endproperty
  a_button_set: assert property (p_button_set) else $error("button flag not set");

  property p_monitor_fall_set;
    @(posedge clk) disable iff (rst)
    (armed_reg && monitor_prev_reg && !supply_voltage_monitor)
      |=> primary_event_flags_reg[SUPPLY_MON_BIT];
  endproperty
  a_monitor_fall_set: assert property (p_monitor_fall_set) else $error("monitor not set");

  property p_hold_fall_set;
    @(posedge clk) disable iff (rst)
    (armed_reg && hold_prev_reg && !power_hold_input)
      |=> primary_event_flags_reg[HOLD_FALL_BIT];
  endproperty
  a_hold_fall_set: assert property (p_hold_fall_set) else $error("hold fall not set");

  property p_linreg3_fall;
    @(posedge clk) disable iff (rst)
    (armed_reg && good_prev_reg[6] && !good_now[6] && enable_now[6] && enable_prev_reg[6])
      |=> regulator_fail_flags_low_reg[6];
  endproperty
  a_linreg3_fall: assert property (p_linreg3_fall) else $error("linreg3 fail not set");

  property p_fail_stays_clear;
    @(posedge clk) disable iff (rst)
    (regulator_fail_flags_low_reg == 8'h00 && fail_set == 8'h00)
      |=> regulator_fail_flags_low_reg == 8'h00;
  endproperty
  a_fail_stays_clear: assert property (p_fail_stays_clear) else $error("fail flag rose");

  property p_irq_quiet;
    @(posedge clk) disable iff (rst)
    !pending |=> !irq_reg;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("request without flag");

  property p_reset_pin_masks;
    @(posedge clk) rst |=> pin_edge_masks_upper_reg == $past(otp_pin_mask_default);
  endproperty
  a_reset_pin_masks: assert property (p_reset_pin_masks) else $error("strap not loaded");
endmodule : pmu_event_flag_mask_bank

// ---- dv/pmu_host_model.sv ----
`timescale 1ns/100ps
// host software stand-in: one-cycle strobes, read data taken one cycle later
module pmu_host_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // callers pass a whole byte: the flag bits they mean to drop, or a new mask value
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : write_reg
  // rdata stands one cycle only, so it is taken at the following edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : read_reg
endmodule : pmu_host_model

// ---- dv/pmu_event_flag_mask_bank_tb_top.sv ----
`timescale 1ns/100ps
module pmu_event_flag_mask_bank_tb_top;
  import pmu_event_pkg::*;
  logic clk, rst, wr, rd, irq, hold, btn, lp, ov, mon;
  logic [7:0] addr, wdata, rdata, otp, d;
  logic [5:1] gp;
  logic [4:1] lin_ok, buck_ok, lin_en, buck_en;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  pmu_event_flag_mask_bank pmu_event_flag_mask_bank_inst (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gp_pin_in(gp),
    .power_hold_input(hold), .button_press_evt(btn), .button_long_press_evt(lp),
    .overtemp_warn_evt(ov), .supply_voltage_monitor(mon),
    .linreg_in_regulation(lin_ok), .buck_in_regulation(buck_ok),
    .linreg_enable(lin_en), .buck_enable(buck_en),
    .otp_pin_mask_default(otp), .irq_req(irq));

  pmu_host_model pmu_host_model_inst (.clk(clk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));

  task automatic summarize;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // a hang costs one mismatch and ends the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    pmu_host_model_inst.read_reg(a, d);
    chk8($sformatf("reg %h", a), e, d);
  endtask : rd_chk

  task automatic test_reset;
    rd_chk(8'h3b, 8'h00);
    rd_chk(8'h3d, 8'h00);
    rd_chk(8'h3c, otp);
    rd_chk(8'h3a, 8'hff);
    rd_chk(8'h40, 8'h00); // unmapped place reads zero
    chk1("irq", 1'b0, irq);
  endtask : test_reset

  // each upper pin (2..5): rise, fall, clear the rise only, then clear all
  task automatic test_pins;
    for (int p = 2; p <= 5; p++) begin
      gp[p] <= 1'b1;
      wait_n(2);
      rd_chk(8'h3b, 8'h01 << (2 * (p - 2)));
      chk1("irq", p >= 4, irq);
      gp[p] <= 1'b0;
      wait_n(2);
      rd_chk(8'h3b, 8'h03 << (2 * (p - 2)));
      pmu_host_model_inst.write_reg(8'h3b, 8'h01 << (2 * (p - 2)));
      rd_chk(8'h3b, 8'h02 << (2 * (p - 2)));
      pmu_host_model_inst.write_reg(8'h3b, 8'hff);
      rd_chk(8'h3b, 8'h00);
    end
    pmu_host_model_inst.write_reg(8'h40, 8'h11);
    pmu_host_model_inst.write_reg(8'h3c, 8'ha5);
    rd_chk(8'h3c, 8'ha5);
  endtask : test_pins

  // prime the level, drop stray flags, then make exactly one event
  task automatic fire(input int b);
    case (b)
      7: gp[1] <= 1'b1;
      0: hold <= 1'b1;
      default: ;
    endcase
    wait_n(3);
    pmu_host_model_inst.write_reg(8'h39, 8'hff);
    case (b)
      7: gp[1] <= 1'b0;
      6: gp[1] <= 1'b1;
      5: ov <= 1'b1;
      4: hold <= 1'b1;
      3: lp <= 1'b1;
      2: btn <= 1'b1;
      1: mon <= 1'b0;
      default: hold <= 1'b0;
    endcase
    @(posedge clk);
    {ov, lp, btn} <= 3'b000;
    mon <= 1'b1;
    wait_n(2);
  endtask : fire

  task automatic test_primary;
    for (int b = 7; b >= 0; b--) begin
      fire(b);
      rd_chk(8'h39, 8'h01 << b);
      chk1("irq", 1'b0, irq);
      pmu_host_model_inst.write_reg(8'h3a, ~(8'h01 << b));
      wait_n(2);
      chk1("irq", 1'b1, irq);
      pmu_host_model_inst.write_reg(8'h3a, 8'hff);
      wait_n(2);
    end
  endtask : test_primary

  // one regulator at a time loses power-good while enabled
  task automatic test_regs;
    for (int i = 0; i < 8; i++) begin
      if (i > 3) lin_ok[i - 3] <= 1'b0;
      else buck_ok[i + 1] <= 1'b0;
      wait_n(2);
      rd_chk(8'h3d, 8'h01 << i);
      {lin_ok, buck_ok} <= 8'hff;
      wait_n(2);
      pmu_host_model_inst.write_reg(8'h3d, 8'h01 << i);
    end
    rd_chk(8'h3d, 8'h00);
    lin_en[3] <= 1'b0;
    wait_n(2);
    lin_ok[3] <= 1'b0;
    wait_n(2);
    rd_chk(8'h3d, 8'h00);
    pmu_host_model_inst.write_reg(8'h3e, 8'h7f);
    lin_ok[4] <= 1'b0;
    wait_n(3);
    chk1("irq", 1'b1, irq);
  endtask : test_regs

  initial begin
    rst = 1'b1;
    gp = 5'h00;
    {hold, btn, lp, ov} = 4'h0;
    mon = 1'b1;
    {lin_ok, buck_ok, lin_en, buck_en} = 16'hffff;
    otp = 8'h0f;
    wait_n(8);
    rst <= 1'b0;
    wait_n(2);
    test_reset();
    test_pins();
    test_primary();
    test_regs();
    summarize();
  end
endmodule : pmu_event_flag_mask_bank_tb_top
